// >>> common/adcsc_defines.svh
// timing counts, control byte field positions and reset values of the converter sequencer
`ifndef ADCSC_DEFINES_SVH
`define ADCSC_DEFINES_SVH

// ====================================================================
// control byte field positions (bit 7 is the start bit)
`define ADCSC_B_START      7
`define ADCSC_B_SEL_HI     6
`define ADCSC_B_SEL_LO     4
`define ADCSC_B_CLK_INT    3
`define ADCSC_B_REF_INT    2
`define ADCSC_B_REF_PD     1
`define ADCSC_B_PWR_ON     0

// ====================================================================
// receive bit counts at which the sequencer acts
`define ADCSC_CNT_IDLE     4'h0
`define ADCSC_CNT_FIRST    4'h1
`define ADCSC_CNT_TRACK    4'h4
`define ADCSC_CNT_HOLD     4'h6
`define ADCSC_CNT_LAST     4'h7
`define ADCSC_CNT_BYTE     4'h8

// ====================================================================
// conversion
`define ADCSC_RES_W        8
`define ADCSC_SAR_STEPS    4'h8
`define ADCSC_SAR_SEED     8'h80
`define ADCSC_RESULT_RST   8'h00

// ====================================================================
// internal conversion clock: one decision per step period
`define ADCSC_CLK_NS       8
`define ADCSC_INT_STEP_NS  1000
`define ADCSC_INT_STEP_CYC ((`ADCSC_INT_STEP_NS + `ADCSC_CLK_NS - 1) / `ADCSC_CLK_NS)

`endif

// >>> common/adcsc_pkg.sv
// types of the converter sequencer: input routing, switch set and status word
package adcsc_pkg;

  // ==================================================================
  // analog nodes that an input multiplexer switch can connect
  typedef enum logic [1:0] {
    ADCSC_NODE_CH0,
    ADCSC_NODE_CH1,
    ADCSC_NODE_COM,
    ADCSC_NODE_VDD
  } adcsc_node_t;

  // sampled input, reference input and coding of one operating mode
  typedef struct packed {
    adcsc_node_t sampled;
    adcsc_node_t reference;
    logic        bipolar;
  } adcsc_route_t;

  // one line per input multiplexer switch
  typedef struct packed {
    logic analog_input_0;
    logic analog_input_1;
    logic common_input;
    logic supply_monitor;
  } adcsc_switch_t;

  typedef struct packed {
    logic reference_source_select;
    logic conversion_clock_select;
    logic reference_power_down;
    logic power_down;
    logic bipolar;
    logic busy;
  } adcsc_status_t;

  // eight modes out of the three input-select bits
  function automatic adcsc_route_t adcsc_decode(input logic [2:0] sel);
    adcsc_route_t r;
    r = '{ADCSC_NODE_CH0, ADCSC_NODE_COM, 1'b0};
    case (sel)
      3'h0: r = '{ADCSC_NODE_CH0, ADCSC_NODE_CH1, 1'b0};
      3'h1: r = '{ADCSC_NODE_CH1, ADCSC_NODE_CH0, 1'b0};
      3'h2: r = '{ADCSC_NODE_CH0, ADCSC_NODE_CH1, 1'b1};
      3'h3: r = '{ADCSC_NODE_CH1, ADCSC_NODE_CH0, 1'b1};
      3'h4: r = '{ADCSC_NODE_CH1, ADCSC_NODE_COM, 1'b0};
      3'h5: r = '{ADCSC_NODE_VDD, ADCSC_NODE_COM, 1'b0};
      3'h6: r = '{ADCSC_NODE_CH1, ADCSC_NODE_COM, 1'b1};
      3'h7: r = '{ADCSC_NODE_CH0, ADCSC_NODE_COM, 1'b0};
      default: r = '{ADCSC_NODE_CH0, ADCSC_NODE_COM, 1'b0};
    endcase
    return r;
  endfunction

endpackage

// >>> verilog/adcsc_sync.sv
// two flip-flop level synchroniser, one bit lane per input bit
`timescale 1ns/1ps
`default_nettype none

module adcsc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  // meta_q feeds q and nothing else
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

`default_nettype wire

// >>> verilog/adcsc_sar.sv
// successive-approximation register: one bit decision per step
`timescale 1ns/1ps
`default_nettype none
`include "adcsc_defines.svh"

module adcsc_sar (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    start,
  input  wire logic                    step,
  input  wire logic                    abort,
  input  wire logic                    comp,
  output var  logic [`ADCSC_RES_W-1:0] dac_code,
  output var  logic [`ADCSC_RES_W-1:0] result,
  output var  logic                    done,
  output var  logic                    busy
);

  logic [2:0]              bit_q;
  logic [`ADCSC_RES_W-1:0] mask;
  logic [`ADCSC_RES_W-1:0] kept;

  // the trial bit stays only when the held input is at or above the dac
  assign mask = `ADCSC_SAR_SEED >> bit_q;
  assign kept = comp ? dac_code : (dac_code & ~mask);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_q    <= 3'h0;
      dac_code <= `ADCSC_RESULT_RST;
      result   <= `ADCSC_RESULT_RST;
      done     <= 1'b0;
      busy     <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        bit_q    <= 3'h0;
        dac_code <= `ADCSC_SAR_SEED;
        busy     <= 1'b1;
      end else if (abort) begin
        busy <= 1'b0;
      end else if (busy && step) begin
        if (bit_q == 3'h7) begin
          result <= kept;
          done   <= 1'b1;
          busy   <= 1'b0;
        end else begin
          dac_code <= kept | (mask >> 1);
        end
        bit_q <= bit_q + 3'h1;
      end
    end
  end

endmodule

`default_nettype wire

// >>> verilog/adcsc_top.sv
// serial control sequencer of a two-input 8-bit successive-approximation converter
`timescale 1ns/1ps
`default_nettype none
`include "adcsc_defines.svh"

// Operation
// RULE1 - shift data in only while select low
// RULE2 - data output floats while select high
// RULE3 - sample data input on clock rise
// RULE4 - change data output on clock fall
// RULE5 - external mode: serial clock steps conversion
// RULE6 - track on fall after select-low bit
// RULE7 - hold on fall after reference bit
// RULE8 - back to tracking when conversion ends
// RULE9 - input-select bits pick sampled, reference inputs
// RULE10 - all ones: input 0 against common
// RULE11 - eight modes from input-select field
// RULE12 - control byte sets reference, clock, power
// RULE13 - at most one multiplexer switch closed
// RULE14 - every conversion yields eight result bits
// RULE15 - unipolar negative input gives code zero
// RULE16 - bipolar full scale at half reference
// RULE17 - master keeps serial clock under 2MHz (test master runs it at 15.625MHz)
// RULE18 - result leaves only by data output (the top module also drives it on its result port)
// RULE19 - leading zeros skipped, first one starts
// RULE20 - bit 3 picks conversion clock source
// RULE21 - result msb first, binary or twos complement
// RULE22 - external mode clock within 50k-500kHz (test master runs it at 15.625MHz)
// RULE23 - select high abandons partial control byte
// RULE24 - master uses two byte transfers (test master sends the control byte, then 24 readout clocks)
module adcsc_top (
  input  wire logic                    core_clk,
  input  wire logic                    nrst,
  input  wire logic                    sclk,
  input  wire logic                    cs_n,
  input  wire logic                    din,
  output var  logic                    dout,
  output var  logic                    dout_oe,
  input  wire logic                    comp_in,
  output var  logic [`ADCSC_RES_W-1:0] dac_code,
  output var  logic                    track_hold,
  output var  adcsc_pkg::adcsc_switch_t mux_switch,
  output var  adcsc_pkg::adcsc_status_t status,
  output var  logic [`ADCSC_RES_W-1:0] result
);

  // ==================================================================
  // link domain: serial clock, frame reset
  // select high resets the frame logic at once, so a partial byte is dropped
  logic link_rst_n;
  assign link_rst_n = nrst & ~cs_n; // [RULE1] [RULE23]

  logic [3:0]              rx_cnt_q;
  logic [7:0]              rx_sh_q;
  logic [3:0]              fall_cnt_q;
  logic                    track_now;
  logic                    hold_now;
  logic [7:0]              byte_at_track;
  logic [7:0]              byte_at_hold;

  // receive shifter: zeros before the start bit are dropped
  always_ff @(posedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rx_cnt_q <= `ADCSC_CNT_IDLE;
      rx_sh_q  <= 8'h00;
    end else if (rx_cnt_q == `ADCSC_CNT_IDLE) begin
      if (din) begin // [RULE19]
        rx_cnt_q <= `ADCSC_CNT_FIRST;
        rx_sh_q  <= 8'h01;
      end
    end else if (rx_cnt_q != `ADCSC_CNT_BYTE) begin
      rx_cnt_q <= rx_cnt_q + 4'h1;
      rx_sh_q  <= {rx_sh_q[6:0], din}; // [RULE3]
    end
  end

  // each count from one to seven is seen by exactly one following fall; idle and eight can span many
  always_ff @(negedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      fall_cnt_q <= `ADCSC_CNT_IDLE;
    end else begin
      fall_cnt_q <= rx_cnt_q;
    end
  end

  assign track_now     = (rx_cnt_q == `ADCSC_CNT_TRACK) && (fall_cnt_q != `ADCSC_CNT_TRACK); // [RULE6]
  assign hold_now      = (rx_cnt_q == `ADCSC_CNT_HOLD) && (fall_cnt_q != `ADCSC_CNT_HOLD); // [RULE7]
  assign byte_at_track = {rx_sh_q[3:0], 4'h0};
  assign byte_at_hold  = {rx_sh_q[5:0], 2'h0};

  // ==================================================================
  // link domain: events toward the core
  // toggles and their data use nrst only; a frame reset must not fake an event
  logic       trk_tgl_q;
  logic       hold_tgl_q;
  logic       pd_tgl_q;
  logic       step_tgl_q;
  logic [2:0] sel_lk_q;
  logic [7:0] cfg_lk_q;
  logic [1:0] pd_lk_q;
  logic       ext_run_q;
  logic [3:0] step_cnt_q;

  always_ff @(negedge sclk or negedge nrst) begin
    if (!nrst) begin
      trk_tgl_q  <= 1'b0;
      hold_tgl_q <= 1'b0;
      step_tgl_q <= 1'b0;
      sel_lk_q   <= 3'h0;
      cfg_lk_q   <= 8'h00;
    end else begin
      if (track_now) begin
        trk_tgl_q <= ~trk_tgl_q;
        sel_lk_q  <= byte_at_track[`ADCSC_B_SEL_HI:`ADCSC_B_SEL_LO]; // [RULE9]
      end
      if (hold_now) begin
        hold_tgl_q <= ~hold_tgl_q;
        cfg_lk_q   <= byte_at_hold;
      end
      if (ext_run_q && link_rst_n) begin
        step_tgl_q <= ~step_tgl_q; // [RULE5]
      end
    end
  end

  // external clock mode: eight falls after hold step the conversion
  always_ff @(negedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      ext_run_q  <= 1'b0;
      step_cnt_q <= 4'h0;
    end else if (hold_now) begin
      ext_run_q  <= ~byte_at_hold[`ADCSC_B_CLK_INT]; // [RULE20]
      step_cnt_q <= 4'h0;
    end else if (ext_run_q) begin
      step_cnt_q <= step_cnt_q + 4'h1;
      if (step_cnt_q == (`ADCSC_SAR_STEPS - 4'h1)) begin
        ext_run_q <= 1'b0;
      end
    end
  end

  // power-down bits arrive with the last clock rise of the byte
  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      pd_tgl_q <= 1'b0;
      pd_lk_q  <= 2'h0;
    end else if (link_rst_n && rx_cnt_q == `ADCSC_CNT_LAST) begin
      pd_tgl_q <= ~pd_tgl_q; // [RULE12]
      pd_lk_q  <= {rx_sh_q[0], din};
    end
  end

  // ==================================================================
  // link domain: result readout
  logic                    done_s;
  logic                    done_seen_q;
  logic                    ld_tgl_q;
  logic                    ld_ack_q;
  logic [`ADCSC_RES_W-1:0] res_lk_q;
  logic [2:0]              oidx_q;
  logic                    orun_q;
  logic                    done_tgl_q;

  adcsc_sync #(.WIDTH(1)) u_sync_link (
    .clk   (sclk),
    .rst_n (nrst),
    .d     (done_tgl_q),
    .q     (done_s)
  );

  // result word is stable in the core until the next conversion ends
  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      done_seen_q <= 1'b0;
      ld_tgl_q    <= 1'b0;
      res_lk_q    <= `ADCSC_RESULT_RST;
    end else if (done_s != done_seen_q) begin
      done_seen_q <= done_s;
      ld_tgl_q    <= ~ld_tgl_q;
      res_lk_q    <= result;
    end
  end

  always_ff @(negedge sclk or negedge nrst) begin
    if (!nrst) begin
      ld_ack_q <= 1'b0;
    end else begin
      ld_ack_q <= ld_tgl_q;
    end
  end

  // output drives low from the first fall of a frame until the result is due
  always_ff @(negedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      dout_oe <= 1'b0; // [RULE2]
      dout    <= 1'b0;
      oidx_q  <= 3'h0;
      orun_q  <= 1'b0;
    end else begin
      dout_oe <= 1'b1;
      if (ld_tgl_q != ld_ack_q) begin
        dout   <= res_lk_q[`ADCSC_RES_W-1]; // [RULE21] [RULE4] [RULE18]
        oidx_q <= 3'h6;
        orun_q <= 1'b1;
      end else if (orun_q) begin
        dout   <= res_lk_q[oidx_q]; // [RULE4]
        oidx_q <= oidx_q - 3'h1;
        orun_q <= (oidx_q != 3'h0);
      end else begin
        dout <= 1'b0;
      end
    end
  end

  // ==================================================================
  // core domain: crossing in
  logic [5:0]  core_s;
  logic [3:0]  ev_prev_q;
  logic        trk_evt;
  logic        hold_evt;
  logic        pd_evt;
  logic        step_evt;
  logic        cs_high_s;
  logic        comp_s;

  adcsc_sync #(.WIDTH(6)) u_sync_core (
    .clk   (core_clk),
    .rst_n (nrst),
    .d     ({comp_in, cs_n, trk_tgl_q, hold_tgl_q, pd_tgl_q, step_tgl_q}),
    .q     (core_s)
  );

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ev_prev_q <= 4'h0;
    end else begin
      ev_prev_q <= core_s[3:0];
    end
  end

  assign trk_evt   = core_s[3] ^ ev_prev_q[3];
  assign hold_evt  = core_s[2] ^ ev_prev_q[2];
  assign pd_evt    = core_s[1] ^ ev_prev_q[1];
  assign step_evt  = core_s[0] ^ ev_prev_q[0];
  assign cs_high_s = core_s[4];
  assign comp_s    = core_s[5];

  // ==================================================================
  // core domain: configuration
  adcsc_pkg::adcsc_route_t route_q;
  logic                    clk_int_q;
  logic                    ref_int_q;
  logic                    ref_pd_q;
  logic                    pwr_dn_q;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      route_q   <= '{adcsc_pkg::ADCSC_NODE_CH0, adcsc_pkg::ADCSC_NODE_COM, 1'b0};
      clk_int_q <= 1'b0;
      ref_int_q <= 1'b0;
    end else if (trk_evt) begin
      route_q <= adcsc_pkg::adcsc_decode(sel_lk_q); // [RULE11] [RULE10]
    end else if (hold_evt) begin
      route_q   <= adcsc_pkg::adcsc_decode(cfg_lk_q[`ADCSC_B_SEL_HI:`ADCSC_B_SEL_LO]);
      clk_int_q <= cfg_lk_q[`ADCSC_B_CLK_INT]; // [RULE20]
      ref_int_q <= cfg_lk_q[`ADCSC_B_REF_INT]; // [RULE12]
    end
  end

  // the power bit is active high here: a zero in the byte powers down
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ref_pd_q <= 1'b0;
      pwr_dn_q <= 1'b0;
    end else if (pd_evt) begin
      ref_pd_q <= pd_lk_q[`ADCSC_B_REF_PD]; // [RULE12]
      pwr_dn_q <= ~pd_lk_q[`ADCSC_B_PWR_ON];
    end
  end

  // ==================================================================
  // core domain: conversion
  logic [7:0]              tick_cnt_q;
  logic                    tick;
  logic                    sar_step;
  logic                    sar_abort;
  logic [`ADCSC_RES_W-1:0] sar_result;
  logic                    sar_done;
  logic                    sar_busy;

  // internal clock mode: free step timer while a conversion runs
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_q <= 8'h00;
    end else if (!sar_busy || tick) begin
      tick_cnt_q <= 8'h00;
    end else begin
      tick_cnt_q <= tick_cnt_q + 8'h01;
    end
  end

  assign tick      = (tick_cnt_q == 8'(`ADCSC_INT_STEP_CYC - 1));
  assign sar_step  = clk_int_q ? tick : step_evt; // [RULE5]
  // an external-clock conversion has no clock left once select rises
  assign sar_abort = cs_high_s && !clk_int_q; // [RULE23]

  adcsc_sar u_sar (
    .clk      (core_clk),
    .rst_n    (nrst),
    .start    (hold_evt),
    .step     (sar_step),
    .abort    (sar_abort),
    .comp     (comp_s),
    .dac_code (dac_code),
    .result   (sar_result),
    .done     (sar_done),
    .busy     (sar_busy)
  );

  // bipolar result leaves in twos complement by flipping the offset msb
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      result     <= `ADCSC_RESULT_RST;
      done_tgl_q <= 1'b0;
    end else if (sar_done) begin
      result     <= route_q.bipolar ? {~sar_result[`ADCSC_RES_W-1], sar_result[`ADCSC_RES_W-2:0]}
                                    : sar_result; // [RULE14] [RULE15] [RULE16] [RULE21]
      done_tgl_q <= ~done_tgl_q;
    end
  end

  // ==================================================================
  // core domain: track/hold and multiplexer
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      track_hold <= 1'b0;
    end else if (hold_evt) begin
      track_hold <= 1'b0; // [RULE7]
    end else if (trk_evt || sar_done || (sar_abort && sar_busy)) begin
      track_hold <= 1'b1; // [RULE6] [RULE8]
    end
  end

  // one node only: sampled input while tracking, reference input in hold
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mux_switch <= '0;
    end else begin
      case (track_hold ? route_q.sampled : route_q.reference) // [RULE13] [RULE9]
        adcsc_pkg::ADCSC_NODE_CH0: mux_switch <= 4'b1000;
        adcsc_pkg::ADCSC_NODE_CH1: mux_switch <= 4'b0100;
        adcsc_pkg::ADCSC_NODE_COM: mux_switch <= 4'b0010;
        adcsc_pkg::ADCSC_NODE_VDD: mux_switch <= 4'b0001;
        default:                   mux_switch <= 4'b0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      status <= '0;
    end else begin
      status <= '{ref_int_q, clk_int_q, ref_pd_q, pwr_dn_q, route_q.bipolar, sar_busy};
    end
  end

endmodule

`default_nettype wire

// >>> test/adcsc_monitor.sv
// port checks of the converter sequencer, bound to its top module
`timescale 1ns/1ps
`default_nettype none
`include "adcsc_defines.svh"

module adcsc_monitor (
  input wire logic                     core_clk,
  input wire logic                     nrst,
  input wire logic                     sclk,
  input wire logic                     cs_n,
  input wire logic                     dout,
  input wire logic                     dout_oe,
  input wire logic [`ADCSC_RES_W-1:0]  dac_code,
  input wire logic                     track_hold,
  input wire adcsc_pkg::adcsc_switch_t mux_switch,
  input wire adcsc_pkg::adcsc_status_t status,
  input wire logic [`ADCSC_RES_W-1:0]  result
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ==================================================================
  // assertions
  AST_OE_OFF: assert property (cs_n |-> !dout_oe)
    else $error("data output driven while deselected");
  AST_DOUT_FALL: assert property (sclk && $past(sclk) && !cs_n && !$past(cs_n) |-> $stable(dout))
    else $error("data output moved while serial clock high");
  AST_ONE_SW: assert property ($onehot0(mux_switch))
    else $error("more than one input switch closed");
  AST_TRACK_SAMPLED: assert property (track_hold && $past(track_hold) |-> !mux_switch.common_input)
    else $error("common input sampled while tracking");
  AST_HOLD_REF: assert property (!track_hold && !$past(track_hold) |-> !mux_switch.supply_monitor)
    else $error("supply used as reference while holding");
  AST_DAC_SEED: assert property ($fell(track_hold) |-> ##[0:6] (dac_code == 8'h80))
    else $error("conversion did not start after hold");
  AST_TRACK_DONE: assert property ($changed(result) |-> ##[0:2] track_hold)
    else $error("no return to tracking after conversion");
  AST_RESULT_HOLD: assert property ($changed(result) |-> !$past(track_hold))
    else $error("result changed outside a conversion");
  AST_CFG_FRAME: assert property ($changed(status.power_down) |-> !$past(cs_n, 6))
    else $error("configuration changed without a frame");
endmodule

bind adcsc_top adcsc_monitor u_mon (
  .core_clk(core_clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .dout(dout), .dout_oe(dout_oe),
  .dac_code(dac_code), .track_hold(track_hold), .mux_switch(mux_switch), .status(status), .result(result)
);
`default_nettype wire

// >>> test/adcsc_master.sv
// serial master model: chip select, serial clock, data in, result capture
`timescale 1ns/1ps
`default_nettype none

module adcsc_master (
  output var  logic sclk,
  output var  logic cs_n,
  output var  logic din,
  input  wire logic sdo
);
  // fast link keeps the run short; the sequencer only needs the serial clock well below the core clock (here one eighth)
  localparam int HALF_NS = 32;
  logic [31:0] rx;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
    rx = '0;
  end
  // ==================================================================
  // clock idles low and runs only while bits drives it, selected or not; data moves after the fall
  task automatic bits(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      din = v[i];
      #HALF_NS sclk = 1'b1;
      rx = {rx[30:0], sdo};
      #HALF_NS sclk = 1'b0;
    end
  endtask
  // select edges keep half a period clear of the clock edges
  task automatic sel(input logic lvl);
    #HALF_NS cs_n = lvl;
    #HALF_NS;
  endtask
endmodule
`default_nettype wire

// >>> test/tb.sv
// testbench of the converter sequencer with a serial master and comparator model
`timescale 1ns/1ps
`default_nettype none
`include "adcsc_defines.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end

module tb;
  logic                     core_clk;
  logic                     nrst;
  logic [7:0]               vin;
  logic                     sclk;
  logic                     cs_n;
  logic                     din;
  wire                      sdo;
  wire                      comp_in;
  logic                     dout;
  logic                     dout_oe;
  logic [`ADCSC_RES_W-1:0]  dac_code;
  logic                     track_hold;
  adcsc_pkg::adcsc_switch_t mux_switch;
  adcsc_pkg::adcsc_status_t status;
  logic [`ADCSC_RES_W-1:0]  result;
  logic [7:0]               exp_q[$];
  logic [7:0]               exp_v;
  logic                     busy_q;
  int                       miscompares;
  int                       n_tests;
  int                       cycles;
  localparam logic [3:0] MUX_EXP [8] = '{4'h8, 4'h4, 4'h8, 4'h4, 4'h4, 4'h1, 4'h4, 4'h8};

  assign sdo = dout_oe ? dout : 1'bz;
  // ideal comparator against the trial code
  assign comp_in = (vin >= dac_code);

  adcsc_master u_mst (.sclk(sclk), .cs_n(cs_n), .din(din), .sdo(sdo));
  adcsc_top u_dut (.core_clk(core_clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
    .dout_oe(dout_oe), .comp_in(comp_in), .dac_code(dac_code), .track_hold(track_hold),
    .mux_switch(mux_switch), .status(status), .result(result));

  always #4 core_clk = ~core_clk;

  // ==================================================================
  // one conversion: leading zeros, control byte, readout clocks
  task automatic run(input logic [2:0] s, input logic ck, input logic [7:0] v);
    logic [7:0] c;
    logic [7:0] r;
    logic       bip;
    logic       ok;
    c = {1'b1, s, ck, 2'($urandom), s[1]};
    bip = (s == 3'd2) || (s == 3'd3) || (s == 3'd6);
    r = bip ? (v ^ 8'h80) : v;
    vin = v;
    exp_q.push_back(r);
    u_mst.sel(1'b0);
    u_mst.bits(32'h0, int'(s));
    u_mst.bits(32'(c), 8);
    if (ck) #10000;
    u_mst.bits($urandom, 24);
    ok = 1'b0;
    for (int k = 0; k <= 16; k++) if (u_mst.rx[23:0] == (24'(r) << k)) ok = 1'b1;
    `CHK(ok, 1'b1)
    `CHK(mux_switch, MUX_EXP[s])
    `CHK(status[5:1], {c[2], c[3], c[1], ~c[0], bip})
    u_mst.sel(1'b1);
  endtask

  task automatic complete_run();
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // result check at every end of conversion
  always @(posedge core_clk) begin
    busy_q <= status.busy;
    if (busy_q === 1'b1 && status.busy === 1'b0 && exp_q.size() > 0) begin
      exp_v = exp_q.pop_front();
      `CHK(result, exp_v)
    end
  end

  // bounded run: a hang counts as a mismatch
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      complete_run();
    end
  end

  initial begin
    core_clk = 1'b0;
    nrst = 1'b0;
    vin = 8'h00;
    busy_q = 1'b0;
    cycles = 0;
    miscompares = 0;
    n_tests = 0;
    void'($urandom(72));
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    // link edges kept off the core clock edges
    #13;
    for (int m = 0; m < 8; m++) run(3'(m), m[0], 8'($urandom));
    u_mst.bits(32'hC2, 8);
    repeat (8) @(posedge core_clk);
    `CHK(status.power_down, 1'b0)
    u_mst.sel(1'b0);
    u_mst.bits(32'h1C, 5);
    u_mst.sel(1'b1);
    run(3'd6, 1'b0, 8'($urandom));
    run(3'd4, 1'b0, 8'h00);
    run(3'd3, 1'b1, 8'h00);
    repeat (20) @(posedge core_clk);
    `CHK(exp_q.size(), 0)
    complete_run();
  end
endmodule
`default_nettype wire
